/* File: tcmp_pkg.sv */
// tcmp_pkg: register map, field positions and reset values of the timer compare block
package tcmp_pkg;
  localparam int unsigned TCMP_AW = 8;
  localparam logic [7:0] TCMP_OFF_CMP = 8'h00;
  localparam logic [7:0] TCMP_OFF_MASK = 8'h04;
  localparam logic [7:0] TCMP_OFF_FLAG = 8'h08;
  localparam logic [7:0] TCMP_OFF_CTRL = 8'h0c;
  localparam logic [7:0] TCMP_OFF_CNT = 8'h10;
  localparam logic [7:0] TCMP_OFF_PORT = 8'h14;
  localparam int unsigned TCMP_BIT_CMP_IE = 7;
  localparam int unsigned TCMP_BIT_OVF_IE = 6;
  localparam int unsigned TCMP_BIT_CMP_F = 7;
  localparam int unsigned TCMP_BIT_OVF_F = 6;
  localparam int unsigned TCMP_BIT_FORCE = 7;
  localparam int unsigned TCMP_BIT_WGM0 = 6;
  localparam int unsigned TCMP_BIT_COM_HI = 5;
  localparam int unsigned TCMP_BIT_COM_LO = 4;
  localparam int unsigned TCMP_BIT_WGM1 = 3;
  localparam int unsigned TCMP_BIT_LATCH = 0;
  localparam int unsigned TCMP_BIT_DIR = 1;
  localparam logic [7:0] TCMP_RST_CMP = 8'h00;
  localparam logic [7:0] TCMP_RST_MASK = 8'h00;
  localparam logic [7:0] TCMP_RST_FLAG = 8'h00;
  localparam logic [7:0] TCMP_RST_CTRL = 8'h00;
  localparam logic [7:0] TCMP_RST_CNT = 8'h00;
  localparam logic [1:0] TCMP_RST_PORT = 2'h0;
  localparam logic [7:0] TCMP_CNT_MAX = 8'hff;
  localparam logic [7:0] TCMP_CNT_BOT = 8'h00;
  localparam logic [1:0] TCMP_RESP_OK = 2'h0;
  localparam logic [1:0] TCMP_RESP_ERR = 2'h2;
  typedef enum logic [1:0] {TCMP_COM_OFF, TCMP_COM_TGL, TCMP_COM_CLR, TCMP_COM_SET} tcmp_com_t;
endpackage

/* File: tcmp_mod_if.sv */
// tcmp_mod_if: signals between the timer core and the pin modulator
`timescale 1ns/1ps
`default_nettype none
interface tcmp_mod_if;
  logic carrier;
  logic modulating;
  logic carrier_en;
  logic modulating_en;
  logic latch;
  logic legacy;
  logic pin_value;
  modport core (output carrier, modulating, carrier_en, modulating_en, latch, legacy,
                input pin_value);
  modport modr (input carrier, modulating, carrier_en, modulating_en, latch, legacy,
                output pin_value);
endinterface
`default_nettype wire

/* File: tcmp_modulator.sv */
// tcmp_modulator: combines the two compare outputs that share one pin
`timescale 1ns/1ps
`default_nettype none
module tcmp_modulator
  import tcmp_pkg::*;
(
  tcmp_mod_if.modr m
);
  logic both_en;
  // no separate enable: both modes nonzero, outside legacy mode, is the enable
  assign both_en = m.carrier_en && m.modulating_en && !m.legacy;

  always_comb begin
    if (both_en) begin
      // latch low gives AND, high gives OR
      m.pin_value = m.latch ? (m.carrier | m.modulating)
                            : (m.carrier & m.modulating);
    end else if (m.carrier_en) begin
      m.pin_value = m.carrier;
    end else if (m.modulating_en) begin
      m.pin_value = m.modulating;
    end else begin
      m.pin_value = m.latch;
    end
  end
endmodule
`default_nettype wire

/* File: tcmp_top.sv */
// tcmp_top: 8-bit timer compare, flags, interrupt requests and shared pin output
// Contract
// - 8-bit compare value, compared with counter continuously
// - compare request needs enable, global enable, flag
// - overflow request needs enable, global enable, flag
// - counter equal compare sets compare flag
// - compare vector execution clears compare flag
// - writing one clears compare flag, zero keeps
// - counter overflow sets overflow flag outside pwm
// - overflow vector or written one clears flag
// - phase pwm sets overflow flag at bottom turn
// - compare, mask, flag reset zero, all read/write
// - enabled compare output overrides pin data latch
// - both outputs enabled turns modulator on
// - modulator combines outputs by and or or
// - direction bit alone enables pin driver
// - no modulation in legacy compatibility mode
// - forced compare moves output, no flag, no request
// - counter write suppresses match on next tick
// - non-pwm modes: off, toggle, clear, set
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcmp_top
  import tcmp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [TCMP_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TCMP_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_tick,
  input wire logic global_irq_enable,
  input wire logic compare_vector_ack,
  input wire logic overflow_vector_ack,
  input wire logic legacy_mode,
  input wire logic modulating_compare_output,
  input wire logic modulating_output_enable,
  output logic compare_irq_req,
  output logic overflow_irq_req,
  output logic shared_output_pin,
  output logic shared_output_pin_oe
);
  // bus state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [TCMP_AW-1:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_data_q, w_data_d;
  logic w_lane_q, w_lane_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_write;
  logic wr_cmp, wr_mask, wr_flag, wr_ctrl, wr_cnt, wr_port;
  // timer state
  logic [7:0] compare_value_q, compare_value_d;
  logic [7:0] timer_interrupt_mask_q, timer_interrupt_mask_d;
  logic [7:0] timer_interrupt_flags_q, timer_interrupt_flags_d;
  logic [6:0] ctrl_q, ctrl_d;
  logic [7:0] counter_value_q, counter_value_d;
  logic count_down_q, count_down_d;
  logic block_q, block_d;
  logic carrier_compare_output_q, carrier_compare_output_d;
  logic shared_pin_data_latch_q, shared_pin_data_latch_d;
  logic shared_pin_direction_q, shared_pin_direction_d;
  logic match, overflow, force_compare_strobe, is_pwm, is_ctc;
  logic [7:0] flag_set, flag_clr;
  tcmp_com_t carrier_output_mode;
  // output state
  logic cmp_irq_q, cmp_irq_d, ovf_irq_q, ovf_irq_d;
  logic pin_q, pin_oe_q;

  tcmp_mod_if mif ();

  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_cmp = do_write && w_lane_q && aw_addr_q == TCMP_OFF_CMP;
  assign wr_mask = do_write && w_lane_q && aw_addr_q == TCMP_OFF_MASK;
  assign wr_flag = do_write && w_lane_q && aw_addr_q == TCMP_OFF_FLAG;
  assign wr_ctrl = do_write && w_lane_q && aw_addr_q == TCMP_OFF_CTRL;
  assign wr_cnt = do_write && w_lane_q && aw_addr_q == TCMP_OFF_CNT;
  assign wr_port = do_write && w_lane_q && aw_addr_q == TCMP_OFF_PORT;

  function automatic logic mapped(input logic [TCMP_AW-1:0] a);
    mapped = a == TCMP_OFF_CMP || a == TCMP_OFF_MASK || a == TCMP_OFF_FLAG ||
             a == TCMP_OFF_CTRL || a == TCMP_OFF_CNT || a == TCMP_OFF_PORT;
  endfunction

  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = {s_axi_awaddr[TCMP_AW-1:2], 2'b00};
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(aw_addr_q) ? TCMP_RESP_OK : TCMP_RESP_ERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = mapped({s_axi_araddr[TCMP_AW-1:2], 2'b00}) ? TCMP_RESP_OK : TCMP_RESP_ERR;
      rdata_d = 32'h0000_0000;
      case ({s_axi_araddr[TCMP_AW-1:2], 2'b00})
        TCMP_OFF_CMP: rdata_d[7:0] = compare_value_q;
        TCMP_OFF_MASK: rdata_d[7:0] = timer_interrupt_mask_q;
        TCMP_OFF_FLAG: rdata_d[7:0] = timer_interrupt_flags_q;
        TCMP_OFF_CTRL: rdata_d[6:0] = ctrl_q; // force strobe reads as zero
        TCMP_OFF_CNT: rdata_d[7:0] = counter_value_q;
        TCMP_OFF_PORT: rdata_d[1:0] = {shared_pin_direction_q, shared_pin_data_latch_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= TCMP_RESP_OK;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= TCMP_RESP_OK;
      rdata_q <= 32'h0000_0000;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_lane_q <= w_lane_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign is_pwm = ctrl_q[TCMP_BIT_WGM0];
  assign is_ctc = ctrl_q[TCMP_BIT_WGM1];
  assign carrier_output_mode = tcmp_com_t'(ctrl_q[TCMP_BIT_COM_HI:TCMP_BIT_COM_LO]);
  // a counter write blanks the very next tick's match
  assign match = timer_tick && !block_q && counter_value_q == compare_value_q;
  assign force_compare_strobe = wr_ctrl && w_data_q[TCMP_BIT_FORCE] && !is_pwm;
  // phase correct flags at the bottom turn, the other modes at max
  assign overflow = timer_tick && (is_pwm && !is_ctc ?
                    count_down_q && counter_value_q == TCMP_CNT_BOT :
                    counter_value_q == TCMP_CNT_MAX);
  assign flag_set = {match, overflow, 6'b00_0000};
  assign flag_clr = (wr_flag ? w_data_q : 8'h00) |
                    {compare_vector_ack, overflow_vector_ack, 6'b00_0000};

  always_comb begin
    compare_value_d = wr_cmp ? w_data_q : compare_value_q;
    timer_interrupt_mask_d = wr_mask ? w_data_q : timer_interrupt_mask_q;
    // set wins over a clear in the same cycle
    timer_interrupt_flags_d = (timer_interrupt_flags_q & ~flag_clr) | flag_set;
    ctrl_d = wr_ctrl ? w_data_q[6:0] : ctrl_q;
    shared_pin_data_latch_d = wr_port ? w_data_q[TCMP_BIT_LATCH] : shared_pin_data_latch_q;
    shared_pin_direction_d = wr_port ? w_data_q[TCMP_BIT_DIR] : shared_pin_direction_q;
    counter_value_d = counter_value_q;
    count_down_d = count_down_q;
    block_d = block_q;
    if (timer_tick) begin
      block_d = 1'b0;
      if (is_pwm && !is_ctc) begin
        if (!count_down_q && counter_value_q == TCMP_CNT_MAX) begin
          count_down_d = 1'b1;
          counter_value_d = counter_value_q - 8'h01;
        end else if (count_down_q && counter_value_q == TCMP_CNT_BOT) begin
          count_down_d = 1'b0;
          counter_value_d = counter_value_q + 8'h01;
        end else begin
          counter_value_d = count_down_q ? counter_value_q - 8'h01 : counter_value_q + 8'h01;
        end
      end else if (is_ctc && !is_pwm && counter_value_q == compare_value_q) begin
        counter_value_d = TCMP_CNT_BOT;
      end else begin
        count_down_d = 1'b0;
        counter_value_d = counter_value_q + 8'h01;
      end
    end
    if (wr_cnt) begin
      counter_value_d = w_data_q;
      block_d = 1'b1;
    end
    carrier_compare_output_d = carrier_compare_output_q;
    if (!is_pwm && (match || force_compare_strobe)) begin
      case (carrier_output_mode)
        TCMP_COM_TGL: carrier_compare_output_d = !carrier_compare_output_q;
        TCMP_COM_CLR: carrier_compare_output_d = 1'b0;
        TCMP_COM_SET: carrier_compare_output_d = 1'b1;
        default: carrier_compare_output_d = carrier_compare_output_q;
      endcase
    end else if (is_pwm && carrier_output_mode[1]) begin
      if (match) begin
        carrier_compare_output_d = carrier_output_mode[0] ^ (!is_ctc && count_down_q);
      end else if (is_ctc && timer_tick && counter_value_q == TCMP_CNT_MAX) begin
        carrier_compare_output_d = !carrier_output_mode[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_value_q <= TCMP_RST_CMP;
      timer_interrupt_mask_q <= TCMP_RST_MASK;
      timer_interrupt_flags_q <= TCMP_RST_FLAG;
      ctrl_q <= TCMP_RST_CTRL[6:0];
      counter_value_q <= TCMP_RST_CNT;
      count_down_q <= 1'b0;
      block_q <= 1'b0;
      carrier_compare_output_q <= 1'b0;
      shared_pin_data_latch_q <= TCMP_RST_PORT[TCMP_BIT_LATCH];
      shared_pin_direction_q <= TCMP_RST_PORT[TCMP_BIT_DIR];
    end else begin
      compare_value_q <= compare_value_d;
      timer_interrupt_mask_q <= timer_interrupt_mask_d;
      timer_interrupt_flags_q <= timer_interrupt_flags_d;
      ctrl_q <= ctrl_d;
      counter_value_q <= counter_value_d;
      count_down_q <= count_down_d;
      block_q <= block_d;
      carrier_compare_output_q <= carrier_compare_output_d;
      shared_pin_data_latch_q <= shared_pin_data_latch_d;
      shared_pin_direction_q <= shared_pin_direction_d;
    end
  end

  assign mif.carrier = carrier_compare_output_q;
  assign mif.modulating = modulating_compare_output;
  assign mif.carrier_en = carrier_output_mode != TCMP_COM_OFF;
  assign mif.modulating_en = modulating_output_enable;
  assign mif.latch = shared_pin_data_latch_q;
  assign mif.legacy = legacy_mode;

  tcmp_modulator u_mod (
    .m(mif.modr)
  );

  always_comb begin
    cmp_irq_d = timer_interrupt_mask_q[TCMP_BIT_CMP_IE] && global_irq_enable &&
                timer_interrupt_flags_q[TCMP_BIT_CMP_F];
    ovf_irq_d = timer_interrupt_mask_q[TCMP_BIT_OVF_IE] && global_irq_enable &&
                timer_interrupt_flags_q[TCMP_BIT_OVF_F];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_irq_q <= 1'b0;
      ovf_irq_q <= 1'b0;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      cmp_irq_q <= cmp_irq_d;
      ovf_irq_q <= ovf_irq_d;
      pin_q <= mif.pin_value;
      pin_oe_q <= shared_pin_direction_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign compare_irq_req = cmp_irq_q;
  assign overflow_irq_req = ovf_irq_q;
  assign shared_output_pin = pin_q;
  assign shared_output_pin_oe = pin_oe_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cmp_irq_gate: assert property ($rose(compare_irq_req) |-> $past(global_irq_enable)
    && $past(timer_interrupt_mask_q[7]) && $past(timer_interrupt_flags_q[7]))
    else $error("compare request without its three conditions");
  a_ovf_irq_gate: assert property (global_irq_enable && timer_interrupt_mask_q[6]
    && timer_interrupt_flags_q[6] |=> overflow_irq_req)
    else $error("overflow request missing");
  a_match_sets_flag: assert property (match |=> timer_interrupt_flags_q[7])
    else $error("match did not set compare flag");
  a_ack_clears_flag: assert property (compare_vector_ack && !match
    |=> !timer_interrupt_flags_q[7])
    else $error("vector ack did not clear compare flag");
  a_w1c_keeps_zero: assert property (wr_flag && !w_data_q[7]
    && timer_interrupt_flags_q[7] && !compare_vector_ack |=> timer_interrupt_flags_q[7])
    else $error("writing zero cleared compare flag");
  a_ovf_at_max: assert property (timer_tick && !is_pwm && counter_value_q == 8'hff
    |=> timer_interrupt_flags_q[6] && counter_value_q == 8'h00 || $past(wr_cnt))
    else $error("overflow at max not flagged");
  a_pwm_ovf_bottom: assert property (is_pwm && !is_ctc && timer_tick && !wr_flag
    && !overflow_vector_ack && counter_value_q != 8'h00 ##1 !$past(timer_interrupt_flags_q[6])
    |-> !timer_interrupt_flags_q[6])
    else $error("phase pwm overflow away from bottom");
  a_force_no_flag: assert property (force_compare_strobe && !match
    && !timer_interrupt_flags_q[7] |=> !timer_interrupt_flags_q[7])
    else $error("forced compare set the flag");
  a_write_blocks: assert property (wr_cnt |=> !match)
    else $error("match right after counter write");
  a_mod_and_or: assert property (carrier_output_mode != TCMP_COM_OFF
    && modulating_output_enable && !legacy_mode |=> shared_output_pin ==
    ($past(shared_pin_data_latch_q) ? $past(carrier_compare_output_q | modulating_compare_output)
    : $past(carrier_compare_output_q & modulating_compare_output)))
    else $error("modulated pin wrong");
  a_oe_follows_dir: assert property (##1 shared_output_pin_oe ==
    $past(shared_pin_direction_q)) else $error("pin enable not from direction bit");

  c_match: cover property (match && timer_interrupt_mask_q[7]);
  c_pwm_turn: cover property (is_pwm && overflow);
  c_mod_or: cover property (mif.carrier_en && mif.modulating_en && shared_pin_data_latch_q);
  c_blocked: cover property (block_q && timer_tick && counter_value_q == compare_value_q);
endmodule
`default_nettype wire

/* File: tcmp_pin_load.sv */
// tcmp_pin_load: external load on the shared output pin, with a weak pull-down
`timescale 1ns/1ps
`default_nettype none
module tcmp_pin_load (
  input wire logic aclk,
  input wire logic pin,
  input wire logic oe,
  output logic level
);
  // an undriven pin falls to the pull-down level, never keeps the last driven value
  // the load sees whole clock cycles only, so modulated pulses lose resolution
  always_ff @(posedge aclk) begin
    level <= oe ? pin : 1'b0;
  end
endmodule
`default_nettype wire

/* File: test_timer2_compare_irq_and_output_modulator.sv */
// test_timer2_compare_irq_and_output_modulator: self-checking bench of the timer compare block
`timescale 1ns/1ps
`default_nettype none
module test_timer2_compare_irq_and_output_modulator;
  import tcmp_pkg::*;
  localparam int MAX_CYC = 20000;
  // row fields: carrier mode, channel enable, channel value, latch, legacy, expected pin
  typedef struct packed {
    logic [1:0] com; logic me; logic m; logic latch; logic legacy; logic exp;
  } tcmp_row_t;
  logic aclk, load_level, compare_irq_req, overflow_irq_req;
  logic shared_output_pin, shared_output_pin_oe;
  logic aresetn = 1'b0, timer_tick = 1'b0, global_irq_enable = 1'b0;
  logic compare_vector_ack = 1'b0, overflow_vector_ack = 1'b0, legacy_mode = 1'b0;
  logic modulating_compare_output = 1'b0, modulating_output_enable = 1'b0;
  logic [TCMP_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  tcmp_row_t rows [12];

  tcmp_top tcmp_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer_tick, .global_irq_enable, .compare_vector_ack,
    .overflow_vector_ack, .legacy_mode, .modulating_compare_output, .modulating_output_enable,
    .compare_irq_req, .overflow_irq_req, .shared_output_pin, .shared_output_pin_oe);
  tcmp_pin_load tcmp_pin_load_i (.aclk(aclk), .pin(shared_output_pin),
    .oe(shared_output_pin_oe), .level(load_level));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYC) begin
      num_errors++;
      $display("Error at %0t: bench timed out", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  // write and data are offered together; each is dropped once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(TCMP_RESP_OK), "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(resp), "read response");
    chk(s_axi_rdata, exp, "read data");
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      timer_tick <= 1'b1;
      @(posedge aclk);
      timer_tick <= 1'b0;
    end
    repeat (2) @(posedge aclk);
  endtask

  task automatic pin_is(input logic e);
    repeat (3) @(posedge aclk);
    chk(32'(load_level), 32'(e), "pin level");
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  initial begin
    rows = '{7'h00, 7'h05, 7'h61, 7'h44, 7'h19, 7'h14, 7'h70, 7'h79, 7'h5d, 7'h54, 7'h73, 7'h5e};
    do_reset();
    // carrier level is forced through the strobe, then the pin shows the combination
    for (int i = 0; i < 12; i++) begin
      wr(TCMP_OFF_CTRL, {2'h0, rows[i].com, 4'h0});
      wr(TCMP_OFF_CTRL, {2'h2, rows[i].com, 4'h0});
      wr(TCMP_OFF_PORT, {6'h00, 1'b1, rows[i].latch});
      modulating_output_enable <= rows[i].me;
      modulating_compare_output <= rows[i].m;
      legacy_mode <= rows[i].legacy;
      pin_is(rows[i].exp);
      chk(32'(shared_output_pin_oe), 32'h1, "pin driver");
    end
    // a second reset in mid-run must zero the compare, mask and flag registers and release the pin
    do_reset();
    chk(32'(shared_output_pin_oe), 32'h0, "pin driver after reset");
    rd(TCMP_OFF_CMP, 32'h0, TCMP_RESP_OK);
    rd(TCMP_OFF_MASK, 32'h0, TCMP_RESP_OK);
    rd(TCMP_OFF_FLAG, 32'h0, TCMP_RESP_OK);
    wr(TCMP_OFF_MASK, 8'hc3);
    rd(TCMP_OFF_MASK, 32'hc3, TCMP_RESP_OK);
    rd(8'h05, 32'hc3, TCMP_RESP_OK);
    wr(TCMP_OFF_CMP, 8'h03);
    rd(TCMP_OFF_CMP, 32'h03, TCMP_RESP_OK);
    rd(8'h18, 32'h0, TCMP_RESP_ERR);
    wr(TCMP_OFF_CNT, 8'h03);
    tick(1);
    rd(TCMP_OFF_FLAG, 32'h00, TCMP_RESP_OK);
    wr(TCMP_OFF_CNT, 8'h02);
    tick(2);
    rd(TCMP_OFF_FLAG, 32'h80, TCMP_RESP_OK);
    chk(32'(compare_irq_req), 32'h0, "request without global enable");
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(compare_irq_req), 32'h1, "compare request");
    chk(32'(overflow_irq_req), 32'h0, "overflow request");
    wr(TCMP_OFF_FLAG, 8'h7f);
    rd(TCMP_OFF_FLAG, 32'h80, TCMP_RESP_OK);
    wr(TCMP_OFF_FLAG, 8'h80);
    rd(TCMP_OFF_FLAG, 32'h00, TCMP_RESP_OK);
    chk(32'(compare_irq_req), 32'h0, "request after clear");
    wr(TCMP_OFF_CNT, 8'h02);
    tick(2);
    chk(32'(compare_irq_req), 32'h1, "compare request again");
    compare_vector_ack <= 1'b1;
    @(posedge aclk);
    compare_vector_ack <= 1'b0;
    rd(TCMP_OFF_FLAG, 32'h00, TCMP_RESP_OK);
    wr(TCMP_OFF_MASK, 8'h40);
    wr(TCMP_OFF_CNT, 8'hff);
    tick(1);
    rd(TCMP_OFF_FLAG, 32'h40, TCMP_RESP_OK);
    chk(32'(overflow_irq_req), 32'h1, "overflow request");
    overflow_vector_ack <= 1'b1;
    @(posedge aclk);
    overflow_vector_ack <= 1'b0;
    rd(TCMP_OFF_FLAG, 32'h00, TCMP_RESP_OK);
    chk(32'(overflow_irq_req), 32'h0, "overflow request cleared");
    wr(TCMP_OFF_CNT, 8'hff);
    tick(1);
    wr(TCMP_OFF_FLAG, 8'h40);
    rd(TCMP_OFF_FLAG, 32'h00, TCMP_RESP_OK);
    // phase pwm: no overflow at the top, one at the bottom turn on the 256th tick
    wr(TCMP_OFF_CTRL, 8'h40);
    wr(TCMP_OFF_CNT, 8'hff);
    tick(1);
    rd(TCMP_OFF_FLAG, 32'h00, TCMP_RESP_OK);
    tick(254);
    rd(TCMP_OFF_FLAG, 32'h80, TCMP_RESP_OK);
    tick(1);
    rd(TCMP_OFF_FLAG, 32'hc0, TCMP_RESP_OK);
    wr(TCMP_OFF_FLAG, 8'hff);
    wr(TCMP_OFF_MASK, 8'h80);
    wr(TCMP_OFF_PORT, 8'h02);
    modulating_output_enable <= 1'b0;
    legacy_mode <= 1'b0;
    wr(TCMP_OFF_CTRL, 8'h30);
    wr(TCMP_OFF_CTRL, 8'hb0);
    pin_is(1'b1);
    wr(TCMP_OFF_CTRL, 8'h20);
    wr(TCMP_OFF_CNT, 8'h02);
    tick(2);
    pin_is(1'b0);
    wr(TCMP_OFF_FLAG, 8'hff);
    wr(TCMP_OFF_CTRL, 8'h10);
    wr(TCMP_OFF_CTRL, 8'h90);
    pin_is(1'b1);
    wr(TCMP_OFF_CTRL, 8'h90);
    pin_is(1'b0);
    rd(TCMP_OFF_FLAG, 32'h00, TCMP_RESP_OK);
    chk(32'(compare_irq_req), 32'h0, "request after forced compare");
    finish_test();
  end
endmodule
`default_nettype wire
